/* File: rtl/ctw_top.sv */
/*
  Split instruction and data caches, translation buffers with a two-level
  table walk, and an eight-entry write buffer, behind one bus port.
  Assumes the core holds each request stable until its ack pulse and that
  the bus answers every beat of a command with one busAck.
*/
// Function
// - Icache 16 KB, 32 ways, 32-byte lines
// - Dcache 16 KB, 32 ways, write-back
// - Icache invalidate-all, round-robin victims
// - Icache enable independent of translation
// - Translation off: every fetch cacheable
// - Dcache invalidate all, line, clean line
// - No hardware clean-all operation
// - Dcache allocates on read misses only
// - Separate 32-entry translation buffers
// - Entries map 4 KB, 64 KB, 1 MB
// - Translation refill slot by round-robin
// - Data single invalidate, fetch all only
// - Faults leave base registers untouched
// - Misses walk two-level tables
// - Addresses are 32 bits wide
// - Write buffer: 8 entries, 16 bytes
// - Buffered only if enabled, translating, bufferable
// - Drain request empties write buffer
// - Separate wrap and merge enables
`timescale 1ns/1ps
`include "ctw_defs.svh"

module ctw_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire ctw_pkg::ctw_core_req_t fetchReq,
  output ctw_pkg::ctw_core_rsp_t fetchRsp,
  input wire ctw_pkg::ctw_core_req_t lsReq,
  output ctw_pkg::ctw_core_rsp_t lsRsp,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output ctw_pkg::ctw_bus_cmd_t busCmd,
  input wire logic busAck,
  input wire logic [31:0] busRdata
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  ctw_pkg::ctw_state_s_t s;
  ctw_pkg::ctw_state_s_t n;
  logic [31:0] iData [0:`CTW_WORDS-1];
  logic [31:0] dData [0:`CTW_WORDS-1];
  logic [22:0] iTag [0:`CTW_LINES-1];
  logic [22:0] dTag [0:`CTW_LINES-1];
  logic iWe;
  logic [3:0] dWe;
  logic iTagWe;
  logic dTagWe;
  logic [11:0] memIdx;
  logic [31:0] memWd;

  // --------------------------------------------------------------------
  // Translation helpers
  // --------------------------------------------------------------------
  function automatic logic [19:0] pgMask(ctw_pkg::ctw_pg_t pg);
    case (pg)
      ctw_pkg::CTW_PG_SECT: pgMask = `CTW_MASK_SECT;
      ctw_pkg::CTW_PG_LARGE: pgMask = `CTW_MASK_LARGE;
      default: pgMask = `CTW_MASK_SMALL;
    endcase
  endfunction

  function automatic logic tlbMatch(ctw_pkg::ctw_tlb_t e, logic [31:0] va);
    tlbMatch = e.valid && ((e.vpn & pgMask(e.pg)) == (va[31:12] & pgMask(e.pg)));
  endfunction

  function automatic logic [31:0] tlbXlate(ctw_pkg::ctw_tlb_t e,
                                           logic [31:0] va);
    logic [19:0] m;
    m = pgMask(e.pg);
    tlbXlate = {(e.ppn & m) | (va[31:12] & ~m), va[11:0]};
  endfunction

  // --------------------------------------------------------------------
  // Lookup
  // --------------------------------------------------------------------
  logic [31:0] iTlbHit;
  logic [31:0] dTlbHit;
  logic [31:0] dTlbOpHit;
  logic [31:0] iWayHit;
  logic [31:0] dWayHit;
  logic [31:0] oWayHit;
  logic [4:0] iTIdx;
  logic [4:0] dTIdx;
  logic [4:0] iWay;
  logic [4:0] dWay;
  logic [4:0] oWay;
  logic [31:0] iPa;
  logic [31:0] dPa;
  logic [3:0] iSet;
  logic [3:0] dSet;
  logic mmuOn;
  logic iTlbAny;
  logic dTlbAny;
  logic iC;
  logic dC;
  logic dB;
  logic iHit;
  logic dHit;
  logic oHit;
  logic bufOk;
  logic canMerge;

  assign iSet = iPa[8:5];
  assign dSet = dPa[8:5];

  // Ways and translation entries are both 32 wide
  for (genvar g = 0; g < `CTW_WAYS; g++) begin : gWay
    assign iTlbHit[g] = tlbMatch(s.iTlb[g], fetchReq.addr);
    assign dTlbHit[g] = tlbMatch(s.dTlb[g], lsReq.addr);
    assign dTlbOpHit[g] = tlbMatch(s.dTlb[g], s.opAddr);
    assign iWayHit[g] = s.iValid[{iSet, 5'(g)}]
                        && (iTag[{iSet, 5'(g)}] == iPa[31:9]);
    assign dWayHit[g] = s.dValid[{dSet, 5'(g)}]
                        && (dTag[{dSet, 5'(g)}] == dPa[31:9]);
    assign oWayHit[g] = s.dValid[{s.opAddr[8:5], 5'(g)}]
                        && (dTag[{s.opAddr[8:5], 5'(g)}] == s.opAddr[31:9]);
  end

  always_comb begin
    iTIdx = 5'h00;
    dTIdx = 5'h00;
    for (int k = 0; k < `CTW_TLB_ENTRIES; k++) begin
      if (iTlbHit[k]) iTIdx = 5'(k);
      if (dTlbHit[k]) dTIdx = 5'(k);
    end
    mmuOn = s.ctrl[`CTW_CTL_MMU];
    iPa = mmuOn ? tlbXlate(s.iTlb[iTIdx], fetchReq.addr) : fetchReq.addr;
    dPa = mmuOn ? tlbXlate(s.dTlb[dTIdx], lsReq.addr) : lsReq.addr;
    iTlbAny = !mmuOn || (|iTlbHit);
    dTlbAny = !mmuOn || (|dTlbHit);
    iC = !mmuOn || s.iTlb[iTIdx].cacheable;
    dC = mmuOn && s.dTlb[dTIdx].cacheable;
    dB = mmuOn && s.dTlb[dTIdx].bufferable;
  end

  always_comb begin
    iWay = 5'h00;
    dWay = 5'h00;
    oWay = 5'h00;
    for (int k = 0; k < `CTW_WAYS; k++) begin
      if (iWayHit[k]) iWay = 5'(k);
      if (dWayHit[k]) dWay = 5'(k);
      if (oWayHit[k]) oWay = 5'(k);
    end
    iHit = iTlbAny && s.ctrl[`CTW_CTL_IC] && iC && (|iWayHit);
    dHit = dTlbAny && s.ctrl[`CTW_CTL_DC] && dC && (|dWayHit);
    oHit = |oWayHit;
    bufOk = s.ctrl[`CTW_CTL_WB] && mmuOn && dTlbAny && dB;
    canMerge = s.ctrl[`CTW_CTL_MERGE] && (s.wbCnt != 4'h0)
               && (s.wb[3'(s.wbTail - 3'h1)].blk == dPa[31:4]);
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  ctw_pkg::ctw_tlb_t tlbE;
  logic tlbWe;
  logic fault;
  logic [3:0] fCode;
  logic [2:0] wIdx;

  always_comb begin
    n = s;
    n.fRsp.ack = 1'b0;
    n.fRsp.abort = 1'b0;
    n.lRsp.ack = 1'b0;
    n.lRsp.abort = 1'b0;
    n.regRdata = 32'h0;
    iWe = 1'b0;
    dWe = 4'h0;
    iTagWe = 1'b0;
    dTagWe = 1'b0;
    memIdx = {s.line, 3'(s.start + s.beat)};
    memWd = busRdata;
    tlbE = '0;
    tlbWe = 1'b0;
    fault = 1'b0;
    fCode = `CTW_FSR_SECT;
    wIdx = canMerge ? 3'(s.wbTail - 3'h1) : s.wbTail;
    case (s.st)
      ctw_pkg::ST_IDLE: begin
        n.beat = 3'h0;
        if (s.opPend) begin
          n.opPend = 1'b0;
          case (s.opCode)
            `CTW_OP_IINV: n.iValid = '0;
            `CTW_OP_DINV: begin
              n.dValid = '0;
              n.dDirty = '0;
            end
            `CTW_OP_DINVL: begin
              if (oHit) begin
                n.dValid[{s.opAddr[8:5], oWay}] = 1'b0;
                n.dDirty[{s.opAddr[8:5], oWay}] = 1'b0;
              end
            end
            `CTW_OP_DCLEAN: begin
              if (oHit && s.dDirty[{s.opAddr[8:5], oWay}]) begin
                n.line = {s.opAddr[8:5], oWay};
                n.nextFill = 1'b0;
                n.st = ctw_pkg::ST_WBACK;
              end
            end
            `CTW_OP_ITLBINV: begin
              for (int k = 0; k < `CTW_TLB_ENTRIES; k++) begin
                n.iTlb[k].valid = 1'b0;
              end
            end
            `CTW_OP_DTLBINV: begin
              for (int k = 0; k < `CTW_TLB_ENTRIES; k++) begin
                n.dTlb[k].valid = 1'b0;
              end
            end
            `CTW_OP_DTLBINVE: begin
              for (int k = 0; k < `CTW_TLB_ENTRIES; k++) begin
                if (dTlbOpHit[k]) n.dTlb[k].valid = 1'b0;
              end
            end
            `CTW_OP_DRAIN: begin
              if (s.wbCnt != 4'h0) begin
                n.opPend = 1'b1;
                n.st = ctw_pkg::ST_DRAIN;
              end
            end
            default: ;
          endcase
        end else if (lsReq.req && !s.lRsp.ack) begin
          n.side = 1'b1;
          n.va = lsReq.addr;
          n.pa = dPa;
          n.sWr = lsReq.write;
          if (dHit && lsReq.write) begin
            dWe = lsReq.be;
            memIdx = {dSet, dWay, dPa[4:2]};
            memWd = lsReq.wdata;
            n.dDirty[{dSet, dWay}] = 1'b1;
            n.lRsp.ack = 1'b1;
          end else if (dHit) begin
            n.lRsp.data = dData[{dSet, dWay, dPa[4:2]}];
            n.lRsp.ack = 1'b1;
          end else if (lsReq.write && bufOk
                       && (canMerge || s.wbCnt != `CTW_WB_ENTRIES)) begin
            if (!canMerge) begin
              n.wb[wIdx] = '0;
              n.wb[wIdx].blk = dPa[31:4];
              n.wbTail = s.wbTail + 3'h1;
              n.wbCnt = s.wbCnt + 4'h1;
            end
            for (int b = 0; b < 4; b++) begin
              if (lsReq.be[b]) begin
                n.wb[wIdx].mask[{dPa[3:2], 2'(b)}] = 1'b1;
                n.wb[wIdx].data[{dPa[3:2], 2'(b), 3'h0} +: 8] =
                  lsReq.wdata[b*8 +: 8];
              end
            end
            n.lRsp.ack = 1'b1;
          end else if (s.wbCnt != 4'h0) begin
            n.st = ctw_pkg::ST_DRAIN;
          end else if (!dTlbAny) begin
            n.pa = {s.ttb[31:14], lsReq.addr[31:20], 2'h0};
            n.st = ctw_pkg::ST_WALK1;
          end else if (s.ctrl[`CTW_CTL_DC] && dC && !lsReq.write) begin
            n.line = {dSet, s.dRr[dSet]};
            n.start = s.ctrl[`CTW_CTL_WRAP] ? dPa[4:2] : 3'h0;
            n.dValid[{dSet, s.dRr[dSet]}] = 1'b0;
            n.nextFill = 1'b1;
            n.st = (s.dValid[{dSet, s.dRr[dSet]}]
                    && s.dDirty[{dSet, s.dRr[dSet]}])
                   ? ctw_pkg::ST_WBACK : ctw_pkg::ST_FILL;
          end else begin
            n.st = ctw_pkg::ST_SINGLE;
          end
        end else if (fetchReq.req && !s.fRsp.ack) begin
          n.side = 1'b0;
          n.va = fetchReq.addr;
          n.pa = iPa;
          n.sWr = 1'b0;
          if (iHit) begin
            n.fRsp.data = iData[{iSet, iWay, iPa[4:2]}];
            n.fRsp.ack = 1'b1;
          end else if (s.wbCnt != 4'h0) begin
            n.st = ctw_pkg::ST_DRAIN;
          end else if (!iTlbAny) begin
            n.pa = {s.ttb[31:14], fetchReq.addr[31:20], 2'h0};
            n.st = ctw_pkg::ST_WALK1;
          end else if (s.ctrl[`CTW_CTL_IC] && iC) begin
            n.line = {iSet, s.iRr[iSet]};
            n.start = s.ctrl[`CTW_CTL_WRAP] ? iPa[4:2] : 3'h0;
            n.iValid[{iSet, s.iRr[iSet]}] = 1'b0;
            n.st = ctw_pkg::ST_FILL;
          end else begin
            n.st = ctw_pkg::ST_SINGLE;
          end
        end
      end
      ctw_pkg::ST_WALK1: begin
        if (busAck) begin
          tlbE.vpn = s.va[31:12];
          tlbE.cacheable = busRdata[3];
          tlbE.bufferable = busRdata[2];
          tlbE.valid = 1'b1;
          tlbE.pg = ctw_pkg::CTW_PG_SECT;
          tlbE.ppn = {busRdata[31:20], 8'h00};
          if (busRdata[1:0] == `CTW_L1_SECT) begin
            tlbWe = 1'b1;
          end else if (busRdata[1:0] == `CTW_L1_COARSE) begin
            n.pa = {busRdata[31:10], s.va[19:12], 2'h0};
            n.st = ctw_pkg::ST_WALK2;
          end else begin
            fault = 1'b1;
          end
        end
      end
      ctw_pkg::ST_WALK2: begin
        if (busAck) begin
          tlbE.vpn = s.va[31:12];
          tlbE.cacheable = busRdata[3];
          tlbE.bufferable = busRdata[2];
          tlbE.valid = 1'b1;
          tlbE.pg = ctw_pkg::CTW_PG_SMALL;
          tlbE.ppn = busRdata[31:12];
          fCode = `CTW_FSR_PAGE;
          if (busRdata[1:0] == `CTW_L2_LARGE) begin
            tlbE.pg = ctw_pkg::CTW_PG_LARGE;
            tlbE.ppn = {busRdata[31:16], 4'h0};
            tlbWe = 1'b1;
          end else if (busRdata[1:0] == `CTW_L2_SMALL) begin
            tlbWe = 1'b1;
          end else begin
            fault = 1'b1;
          end
        end
      end
      ctw_pkg::ST_WBACK: begin
        if (busAck) begin
          n.beat = s.beat + 3'h1;
          if (s.beat == `CTW_LINE_LAST) begin
            n.dDirty[s.line] = 1'b0;
            n.st = s.nextFill ? ctw_pkg::ST_FILL : ctw_pkg::ST_IDLE;
          end
        end
      end
      ctw_pkg::ST_FILL: begin
        if (busAck) begin
          iWe = !s.side;
          dWe = {4{s.side}};
          n.beat = s.beat + 3'h1;
          if (s.beat == `CTW_LINE_LAST) begin
            n.st = ctw_pkg::ST_IDLE;
            if (s.side) begin
              dTagWe = 1'b1;
              n.dValid[s.line] = 1'b1;
              n.dRr[s.line[8:5]] = s.line[4:0] + 5'h01;
            end else begin
              iTagWe = 1'b1;
              n.iValid[s.line] = 1'b1;
              n.iRr[s.line[8:5]] = s.line[4:0] + 5'h01;
            end
          end
        end
      end
      ctw_pkg::ST_SINGLE: begin
        if (busAck) begin
          n.st = ctw_pkg::ST_IDLE;
          if (s.side) begin
            n.lRsp.ack = 1'b1;
            if (!s.sWr) n.lRsp.data = busRdata;
          end else begin
            n.fRsp.ack = 1'b1;
            n.fRsp.data = busRdata;
          end
        end
      end
      ctw_pkg::ST_DRAIN: begin
        if (busAck) begin
          n.beat = s.beat + 3'h1;
          if (s.beat == `CTW_WB_LAST) begin
            n.wbHead = s.wbHead + 3'h1;
            n.wbCnt = s.wbCnt - 4'h1;
            n.st = ctw_pkg::ST_IDLE;
          end
        end
      end
      default: n.st = ctw_pkg::ST_IDLE;
    endcase
    if (tlbWe) begin
      n.st = ctw_pkg::ST_IDLE;
      if (s.side) begin
        n.dTlb[s.dTlbRr] = tlbE;
        n.dTlbRr = s.dTlbRr + 5'h01;
      end else begin
        n.iTlb[s.iTlbRr] = tlbE;
        n.iTlbRr = s.iTlbRr + 5'h01;
      end
    end
    if (fault) begin
      n.st = ctw_pkg::ST_IDLE;
      n.fRsp.ack = !s.side;
      n.fRsp.abort = !s.side;
      n.lRsp.ack = s.side;
      n.lRsp.abort = s.side;
      if (s.side) begin
        n.fsr = fCode;
        n.far = s.va;
      end
    end
    // Bus command follows the next state
    n.bus.req = n.st != ctw_pkg::ST_IDLE;
    n.bus.write = 1'b0;
    n.bus.addr = n.pa;
    n.bus.beats = 3'h0;
    n.bus.be = 4'hF;
    n.bus.wdata = 32'h0;
    n.bus.wrap = s.ctrl[`CTW_CTL_WRAP];
    n.bus.merge = s.ctrl[`CTW_CTL_MERGE];
    case (n.st)
      ctw_pkg::ST_FILL: begin
        n.bus.addr = {n.pa[31:5], n.start, 2'h0};
        n.bus.beats = `CTW_LINE_LAST;
      end
      ctw_pkg::ST_SINGLE: begin
        n.bus.addr = {n.pa[31:2], 2'h0};
        n.bus.write = n.sWr;
        n.bus.be = n.sWr ? lsReq.be : 4'hF;
        n.bus.wdata = n.sWr ? lsReq.wdata : 32'h0;
      end
      ctw_pkg::ST_WBACK: begin
        n.bus.addr = {dTag[n.line], n.line[8:5], 5'h00};
        n.bus.write = 1'b1;
        n.bus.beats = `CTW_LINE_LAST;
        n.bus.wdata = dData[{n.line, n.beat}];
      end
      ctw_pkg::ST_DRAIN: begin
        n.bus.addr = {n.wb[n.wbHead].blk, 4'h0};
        n.bus.write = 1'b1;
        n.bus.beats = `CTW_WB_LAST;
        n.bus.be = n.wb[n.wbHead].mask[{n.beat[1:0], 2'h0} +: 4];
        n.bus.wdata = n.wb[n.wbHead].data[{n.beat[1:0], 5'h00} +: 32];
      end
      default: ;
    endcase
    // Register port, applied last so a new operation wins
    if (regWr) begin
      case (regAddr)
        `CTW_REG_CTRL: n.ctrl = regWdata[5:0];
        `CTW_REG_TTB: n.ttb = regWdata;
        `CTW_REG_OPADDR: n.opAddr = regWdata;
        `CTW_REG_OP: begin
          n.opPend = 1'b1;
          n.opCode = regWdata[3:0];
        end
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        `CTW_REG_CTRL: n.regRdata = {26'h0, s.ctrl};
        `CTW_REG_TTB: n.regRdata = s.ttb;
        `CTW_REG_FSR: n.regRdata = {28'h0, s.fsr};
        `CTW_REG_FAR: n.regRdata = s.far;
        `CTW_REG_OPADDR: n.regRdata = s.opAddr;
        `CTW_REG_STATUS: n.regRdata = {26'h0, s.opPend,
                                      s.st != ctw_pkg::ST_IDLE, s.wbCnt};
        default: n.regRdata = 32'h0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Registers and arrays
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (iWe) iData[memIdx] <= memWd;
    for (int b = 0; b < 4; b++) begin
      if (dWe[b]) dData[memIdx][b*8 +: 8] <= memWd[b*8 +: 8];
    end
    if (iTagWe) iTag[s.line] <= s.pa[31:9];
    if (dTagWe) dTag[s.line] <= s.pa[31:9];
  end

  assign fetchRsp = s.fRsp;
  assign lsRsp = s.lRsp;
  assign busCmd = s.bus;
  assign regRdata = s.regRdata;

endmodule

/* File: rtl/ctw_defs.svh */
/*
  Constants of the cache, translation and write buffer block: register
  offsets, control fields, operation codes, geometry and descriptor codes.
  Assumes it is included by bare name wherever the block is compiled.
*/
`ifndef CTW_DEFS_SVH
`define CTW_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CTW_REG_CTRL 8'h00
`define CTW_REG_TTB 8'h04
`define CTW_REG_FSR 8'h08
`define CTW_REG_FAR 8'h0C
`define CTW_REG_OPADDR 8'h10
`define CTW_REG_OP 8'h14
`define CTW_REG_STATUS 8'h18

// ----------------------------------------------------------------------
// Control fields and reset value
// ----------------------------------------------------------------------
`define CTW_CTL_MMU 0
`define CTW_CTL_DC 1
`define CTW_CTL_IC 2
`define CTW_CTL_WB 3
`define CTW_CTL_WRAP 4
`define CTW_CTL_MERGE 5
`define CTW_CTRL_RST 6'h00

// ----------------------------------------------------------------------
// Maintenance operation codes
// ----------------------------------------------------------------------
`define CTW_OP_IINV 4'h1
`define CTW_OP_DINV 4'h2
`define CTW_OP_DINVL 4'h3
`define CTW_OP_DCLEAN 4'h4
`define CTW_OP_ITLBINV 4'h5
`define CTW_OP_DTLBINV 4'h6
`define CTW_OP_DTLBINVE 4'h7
`define CTW_OP_DRAIN 4'h8

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define CTW_WAYS 32
`define CTW_TLB_ENTRIES 32
`define CTW_LINES 512
`define CTW_WORDS 4096
`define CTW_WB_ENTRIES 4'h8
`define CTW_LINE_LAST 3'h7
`define CTW_WB_LAST 3'h3

// ----------------------------------------------------------------------
// Descriptors, page masks, fault codes
// ----------------------------------------------------------------------
`define CTW_L1_COARSE 2'h1
`define CTW_L1_SECT 2'h2
`define CTW_L2_LARGE 2'h1
`define CTW_L2_SMALL 2'h2
`define CTW_MASK_SECT 20'hFFF00
`define CTW_MASK_LARGE 20'hFFFF0
`define CTW_MASK_SMALL 20'hFFFFF
`define CTW_FSR_SECT 4'h5
`define CTW_FSR_PAGE 4'h7

`endif

/* File: rtl/ctw_pkg.sv */
/*
  Types of the cache, translation and write buffer block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ctw_pkg;

  typedef enum logic [1:0] {CTW_PG_SMALL, CTW_PG_LARGE, CTW_PG_SECT} ctw_pg_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WALK1, ST_WALK2, ST_WBACK, ST_FILL, ST_SINGLE, ST_DRAIN
  } ctw_state_t;

  typedef struct packed {
    logic valid;
    ctw_pg_t pg;
    logic [19:0] vpn;
    logic [19:0] ppn;
    logic cacheable;
    logic bufferable;
  } ctw_tlb_t;

  typedef struct packed {
    logic [27:0] blk;
    logic [15:0] mask;
    logic [127:0] data;
  } ctw_wb_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } ctw_core_req_t;

  typedef struct packed {
    logic ack;
    logic abort;
    logic [31:0] data;
  } ctw_core_rsp_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [2:0] beats;
    logic wrap;
    logic merge;
    logic [3:0] be;
    logic [31:0] wdata;
  } ctw_bus_cmd_t;

  typedef struct packed {
    ctw_state_t st;
    logic [5:0] ctrl;
    logic [31:0] ttb;
    logic [3:0] fsr;
    logic [31:0] far;
    logic [31:0] opAddr;
    logic opPend;
    logic [3:0] opCode;
    logic [511:0] iValid;
    logic [511:0] dValid;
    logic [511:0] dDirty;
    logic [15:0][4:0] iRr;
    logic [15:0][4:0] dRr;
    ctw_tlb_t [31:0] iTlb;
    ctw_tlb_t [31:0] dTlb;
    logic [4:0] iTlbRr;
    logic [4:0] dTlbRr;
    ctw_wb_t [7:0] wb;
    logic [2:0] wbHead;
    logic [2:0] wbTail;
    logic [3:0] wbCnt;
    logic side;
    logic sWr;
    logic nextFill;
    logic [31:0] va;
    logic [31:0] pa;
    logic [8:0] line;
    logic [2:0] beat;
    logic [2:0] start;
    ctw_core_rsp_t fRsp;
    ctw_core_rsp_t lRsp;
    ctw_bus_cmd_t bus;
    logic [31:0] regRdata;
  } ctw_state_s_t;

endpackage

/* File: bench/ctw_top_assertions.sv */
/* Port assertions of ctw_top; assumes a bind to ctw_top. */
`timescale 1ns/1ps
module ctw_top_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire ctw_pkg::ctw_core_rsp_t fetchRsp,
  input wire ctw_pkg::ctw_core_rsp_t lsRsp,
  input wire ctw_pkg::ctw_bus_cmd_t busCmd,
  input wire logic busAck
);
  // ------
  // Checks
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_beats_legal: assert property (busCmd.req |->
    busCmd.beats inside {3'h0, 3'h3, 3'h7}) else $error("beats");
  a_read_whole: assert property (busCmd.req && !busCmd.write |->
    busCmd.beats != 3'h3) else $error("read beats");
  a_fill_start: assert property (busCmd.req && !busCmd.write &&
    busCmd.beats == 3'h7 && !busCmd.wrap |-> busCmd.addr[4:0] == 5'h0)
    else $error("fill start");
  a_drain_block: assert property (busCmd.req && busCmd.write &&
    busCmd.beats == 3'h3 |-> busCmd.addr[3:0] == 4'h0) else $error("drain");
  a_wback_line: assert property (busCmd.req && busCmd.write &&
    busCmd.beats == 3'h7 |-> busCmd.addr[4:0] == 5'h0) else $error("wback");
  a_cmd_holds: assert property (busCmd.req && !busAck |=>
    busCmd.req && $stable({busCmd.addr, busCmd.beats, busCmd.write,
    busCmd.wrap, busCmd.merge})) else $error("command moved");
  a_fetch_abort: assert property (fetchRsp.abort |->
    fetchRsp.ack) else $error("fetch abort");
  a_ls_abort: assert property (lsRsp.abort |-> lsRsp.ack)
    else $error("data abort");
endmodule
bind ctw_top ctw_top_assertions u_chk (.clk(clk), .reset_n(reset_n),
  .fetchRsp(fetchRsp), .lsRsp(lsRsp), .busCmd(busCmd), .busAck(busAck));

/* File: bench/ctw_bus_model.sv */
/* Bus memory model; assumes commands hold until their last beat. */
`timescale 1ns/1ps
module ctw_bus_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire ctw_pkg::ctw_bus_cmd_t busCmd,
  input wire logic slow,
  output logic busAck,
  output logic [31:0] busRdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wlog [$];
  logic [31:0] a;
  logic [2:0] beat;
  logic [1:0] dly;
  logic go;
  int cmds;
  // -----
  // Beats
  // -----
  always_comb begin
    a = busCmd.addr + {27'h0, beat, 2'h0};
    if (busCmd.beats == 3'h7)
      a[31:5] = busCmd.addr[31:5];
    go = busCmd.req && !busAck && (!slow || dly == 2'h3);
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {busAck, busRdata, beat, dly} <= '0;
      cmds = 0;
    end else begin
      dly <= dly + 2'h1;
      busAck <= go;
      busRdata <= go && !busCmd.write ?
        (mem.exists(a) ? mem[a] : a ^ 32'h5A5A0000) : ~busRdata;
      if (busAck && busCmd.req) begin
        beat <= beat == busCmd.beats ? 3'h0 : beat + 3'h1;
        if (beat == busCmd.beats)
          cmds++;
        if (busCmd.write && busCmd.be != 4'h0) begin
          mem[a] = busCmd.wdata;
          wlog.push_back(a);
        end
      end
    end
  end
endmodule

/* File: bench/ctw_top_tb.sv */
/* Bench of ctw_top; assumes ctw_bus_model on the bus port. */
`timescale 1ns/1ps
module ctw_top_tb;
  logic clk = 1'b0;
  logic reset_n, regWr, regRd, busAck, slow, ab;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, busRdata, v;
  ctw_pkg::ctw_core_req_t fetchReq, lsReq;
  ctw_pkg::ctw_core_rsp_t fetchRsp, lsRsp;
  ctw_pkg::ctw_bus_cmd_t busCmd;
  int errors, n_tests, n;
  logic [7:0] ta [5] = '{8'h00, 8'h04, 8'h10, 8'h40, 8'h08};
  logic [31:0] tw [5] = '{32'h20, 32'h4000, 32'h12345678, 32'h1, 32'h1};
  logic [31:0] te [5] = '{32'h20, 32'h4000, 32'h12345678, 32'h0, 32'h0};
  ctw_top dut (.clk(clk), .reset_n(reset_n), .fetchReq(fetchReq),
    .fetchRsp(fetchRsp), .lsReq(lsReq), .lsRsp(lsRsp), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .busCmd(busCmd), .busAck(busAck),
    .busRdata(busRdata));
  ctw_bus_model bus (.clk(clk), .reset_n(reset_n), .busCmd(busCmd),
    .slow(slow), .busAck(busAck), .busRdata(busRdata));
  initial forever #20 clk = ~clk;
  // -----
  // Tasks
  // -----
  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      errors++;
    end
  endtask
  task automatic rg(bit w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    {regAddr, regWdata, regWr, regRd} <= {a, d, w, !w};
    @(posedge clk);
    {regWr, regRd} <= 2'h0;
    #1 v = regRdata;
  endtask
  task automatic acc(bit f, bit w, logic [31:0] a, logic [31:0] d);
    ctw_pkg::ctw_core_rsp_t r;
    @(posedge clk);
    if (f) fetchReq <= '{1'b1, w, a, d, 4'hF};
    else lsReq <= '{1'b1, w, a, d, 4'hF};
    for (int i = 0; i < 3000 && r.ack !== 1'b1; i++) begin
      @(posedge clk);
      r = f ? fetchRsp : lsRsp;
    end
    fetchReq.req <= 1'b0;
    lsReq.req <= 1'b0;
    {v, ab} = {r.data, r.abort};
    if (r.ack !== 1'b1) begin
      errors++;
      wrap_up;
    end
  endtask
  task automatic idle;
    for (int c = 0; c < 300; c++) begin
      rg(0, 8'h18, 32'h0);
      if (v[5:4] === 2'h0)
        return;
    end
    errors++;
    wrap_up;
  endtask
  initial begin
    {reset_n, regWr, regRd, slow, regAddr, regWdata} = '0;
    {fetchReq, lsReq} = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rg(0, 8'h00, 32'h0);
    chk("ctrl reset", v, 32'h0);
    for (int k = 0; k < 5; k++) begin
      rg(1, ta[k], tw[k]);
      rg(0, ta[k], 32'h0);
      chk("register", v, te[k]);
    end
    $display("test registers done");
    rg(1, 8'h00, 32'h4);
    acc(0, 1, 32'h300, 32'hCAFE0001);
    chk("direct store", bus.mem[32'h300], 32'hCAFE0001);
    acc(1, 0, 32'h204, 32'h0);
    chk("fetch fill", v, 32'h5A5A0204);
    n = bus.cmds;
    acc(1, 0, 32'h21C, 32'h0);
    chk("fetch hit", bus.cmds, n);
    rg(1, 8'h14, 32'h1);
    acc(1, 0, 32'h21C, 32'h0);
    chk("fetch refill", bus.cmds, n + 1);
    $display("test fetch done");
    bus.mem[32'h4004] = 32'h0020000E;
    bus.mem[32'h4010] = 32'h00500006;
    rg(1, 8'h00, 32'h1B);
    slow <= 1'b1;
    acc(0, 0, 32'h00100014, 32'h0);
    chk("walk fill", v, 32'h5A7A0014);
    n = bus.cmds;
    acc(0, 1, 32'h00100018, 32'hBEEF);
    chk("store hit", bus.cmds, n);
    acc(0, 1, 32'h00400000, 32'h11);
    acc(0, 1, 32'h00400010, 32'h22);
    rg(1, 8'h14, 32'h8);
    idle;
    chk("drain", v, 32'h0);
    chk("order 1", bus.wlog[1], 32'h00500000);
    chk("order 2", bus.wlog[2], 32'h00500010);
    rg(1, 8'h00, 32'h3B);
    acc(0, 1, 32'h00400004, 32'h33);
    acc(0, 1, 32'h00400008, 32'h44);
    n = bus.cmds;
    rg(1, 8'h14, 32'h8);
    idle;
    chk("merge", bus.cmds, n + 1);
    chk("merged data", bus.mem[32'h00500008], 32'h44);
    rg(1, 8'h10, 32'h00200000);
    rg(1, 8'h14, 32'h4);
    idle;
    chk("clean", bus.mem[32'h00200018], 32'hBEEF);
    $display("test data done");
    acc(0, 0, 32'h00300000, 32'h0);
    chk("abort", {31'h0, ab}, 32'h1);
    acc(1, 0, 32'h00300000, 32'h0);
    chk("fetch abort", {31'h0, ab}, 32'h1);
    rg(0, 8'h04, 32'h0);
    chk("base kept", v, 32'h4000);
    rg(1, 8'h10, 32'h00100014);
    rg(1, 8'h14, 32'h7);
    n = bus.cmds;
    acc(0, 0, 32'h00100014, 32'h0);
    chk("entry flush", bus.cmds, n + 1);
    $display("test fault done");
    wrap_up;
  end
endmodule
